// ===== design/mbd_consts.vh
// Constants for the slave diagnostic and exception block.
// Assumes inclusion by bare name from the design folder.
`ifndef MBD_CONSTS_VH
`define MBD_CONSTS_VH
`define MBD_FC_DIAG      8'h08
`define MBD_FC_EVCNT     8'h0B
`define MBD_SUB_CLEAR    16'h000A
`define MBD_SUB_FIRST    16'h000B
`define MBD_SUB_LAST     16'h0012
`define MBD_EXC_FLAG     8'h80
`define MBD_EXC_FUNC     8'h01
`define MBD_EXC_ADDR     8'h02
`define MBD_EXC_VALUE    8'h03
`define MBD_EXC_FAIL     8'h04
`define MBD_EXC_ACK      8'h05
`define MBD_EXC_BUSY     8'h06
`define MBD_EXC_NAK      8'h07
`define MBD_EXC_PARITY   8'h08
`define MBD_EXC_GW_PATH  8'h0A
`define MBD_EXC_GW_TGT   8'h0B
`define MBD_ADDR_MIN     8'h01
`define MBD_ADDR_MAX     8'hF7
`define MBD_CNT_MAX      16'hFFFF
`define MBD_CNT_RESET    16'h0000
`define MBD_REPLY_NORMAL 2'h1
`define MBD_REPLY_EXC    2'h2
`define MBD_REPLY_NONE   2'h0
`define MBD_APP_OK       4'h0
`define MBD_APP_UNIMPL   4'hC
`endif

// ===== design/mbd_slave_diag.v
// Slave-side diagnostic counters and reply decision for a serial bus device.
// Assumes an upstream frame decoder giving one-cycle request pulses with
// CRC checked, and a downstream framer that appends the CRC16 to replies.
// Assumes link_cfg_changed comes from another domain and toggles per change.
`timescale 1ns/100ps
`default_nettype none
`include "mbd_consts.vh"
module mbd_slave_diag #(
	parameter CW = 16
) (
	input  wire          clk,
	input  wire          rstn,
	input  wire          req_valid,
	input  wire [7:0]    req_addr,
	input  wire [7:0]    req_func,
	input  wire [15:0]   req_sub,
	input  wire          req_comm_err,
	input  wire          req_overrun,
	input  wire          req_lost,
	input  wire [3:0]    app_status,
	input  wire [7:0]    own_addr,
	input  wire          link_cfg_changed,
	output reg           rsp_valid,
	output reg  [1:0]    rsp_kind,
	output reg  [7:0]    rsp_slave,
	output reg  [7:0]    rsp_func,
	output reg  [7:0]    rsp_exc_code,
	output reg  [CW-1:0] rsp_word,
	output reg           rsp_word_valid
);
	// ----------------------------------------------------------------
	// Counter bank layout
	// ----------------------------------------------------------------
	localparam NCNT      = 9;
	localparam C_BUS_MSG = 4'h0;
	localparam C_BUS_ERR = 4'h1;
	localparam C_EXC     = 4'h2;
	localparam C_SLAVE   = 4'h3;
	localparam C_NO_RSP  = 4'h4;
	localparam C_NAK     = 4'h5;
	localparam C_BUSY    = 4'h6;
	localparam C_OVERRUN = 4'h7;
	localparam C_EVENT   = 4'h8;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	reg  [CW-1:0]   cnt [0:NCNT-1];
	reg  [1:0]      cfg_sync;
	reg             cfg_seen;
	reg  [NCNT-1:0] bump;
	reg  [7:0]      exc;
	reg             next_valid;
	reg  [1:0]      next_kind;
	reg  [7:0]      next_slave;
	reg  [7:0]      next_func;
	reg  [7:0]      next_exc_code;
	reg  [CW-1:0]   next_word;
	reg             next_word_valid;
	integer         i;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Next count; the top value rolls over to zero, never saturates.
	function [CW-1:0] inc;
		input [CW-1:0] v;
		begin
			if (v == {CW{1'b1}})
				inc = {CW{1'b0}};
			else
				inc = v + {{(CW-1){1'b0}}, 1'b1};
		end
	endfunction

	// Slave numbers that may carry a reply.
	function in_range;
		input [7:0] a;
		begin
			if (a < `MBD_ADDR_MIN)
				in_range = 1'b0;
			else if (a > `MBD_ADDR_MAX)
				in_range = 1'b0;
			else
				in_range = 1'b1;
		end
	endfunction

	// Sub-functions that read back one counter.
	function is_readout;
		input [15:0] s;
		begin
			if (s < `MBD_SUB_FIRST)
				is_readout = 1'b0;
			else if (s > `MBD_SUB_LAST)
				is_readout = 1'b0;
			else
				is_readout = 1'b1;
		end
	endfunction

	// Bank index of the counter read by a readout sub-function.
	function [3:0] bank_index;
		input [15:0] s;
		reg   [15:0] d;
		begin
			d          = s - `MBD_SUB_FIRST;
			bank_index = d[3:0];
		end
	endfunction

	// Exception code for a good request; zero means none.
	function [7:0] exc_code;
		input [3:0]  status;
		input [7:0]  func;
		input [15:0] sub;
		begin
			if (status == `MBD_APP_UNIMPL)
				exc_code = `MBD_EXC_ADDR;
			else if (status != `MBD_APP_OK)
				exc_code = {4'h0, status};
			else if (func == `MBD_FC_DIAG && !is_readout(sub) && sub != `MBD_SUB_CLEAR)
				exc_code = `MBD_EXC_VALUE;
			else
				exc_code = 8'h00;
		end
	endfunction

	// ----------------------------------------------------------------
	// Request classification
	// ----------------------------------------------------------------
	wire cfg_edge = cfg_sync[1] ^ cfg_seen;
	wire bcast    = (req_addr == 8'h00);
	wire mine     = (req_addr == own_addr);
	wire to_us    = mine | bcast;
	wire bad      = req_comm_err | req_overrun;
	wire good     = req_valid & ~bad & ~req_lost;
	wire is_diag  = (req_func == `MBD_FC_DIAG);
	wire is_ev    = (req_func == `MBD_FC_EVCNT);
	wire sub_ok   = is_readout(req_sub);
	wire is_clr   = good & to_us & is_diag & (req_sub == `MBD_SUB_CLEAR);
	wire clr_all  = cfg_edge | is_clr;
	wire answer   = good & mine & in_range(req_addr);

	always @* begin
		exc = exc_code(app_status, req_func, req_sub);
	end

	// ----------------------------------------------------------------
	// Exception outcome
	// ----------------------------------------------------------------
	wire is_exc   = good & mine & (exc != 8'h00);
	wire is_nak   = is_exc & (exc == `MBD_EXC_NAK);
	wire is_busy  = is_exc & (exc == `MBD_EXC_BUSY);

	// ----------------------------------------------------------------
	// Link setting synchroniser
	// ----------------------------------------------------------------
	// Two flops bring the line into this domain; a third holds the last
	// level so that either edge clears the counters.
	always @(posedge clk) begin
		if (!rstn) begin
			cfg_sync <= 2'h0;
			cfg_seen <= 1'b0;
		end else begin
			cfg_sync <= {cfg_sync[0], link_cfg_changed};
			cfg_seen <= cfg_sync[1];
		end
	end

	// ----------------------------------------------------------------
	// Counter events
	// ----------------------------------------------------------------
	always @* begin
		bump = {NCNT{1'b0}};
		if (req_valid) begin
			bump[C_BUS_MSG] = good & to_us;
			bump[C_BUS_ERR] = bad;
			bump[C_EXC]     = is_exc | (bad & bcast);
			bump[C_SLAVE]   = good & mine;
			bump[C_NO_RSP]  = good & bcast;
			bump[C_NAK]     = is_nak;
			bump[C_BUSY]    = is_busy;
			bump[C_OVERRUN] = req_overrun;
			bump[C_EVENT]   = good & to_us & ~is_ev;
		end
	end

	// ----------------------------------------------------------------
	// Counter bank
	// ----------------------------------------------------------------
	// A clear wins over any count in the same cycle, so the clearing
	// request itself is not counted.
	always @(posedge clk) begin
		if (!rstn) begin
			for (i = 0; i < NCNT; i = i + 1)
				cnt[i] <= {CW{1'b0}};
		end else begin
			for (i = 0; i < NCNT; i = i + 1) begin
				if (clr_all)
					cnt[i] <= {CW{1'b0}};
				else if (bump[i])
					cnt[i] <= inc(cnt[i]);
			end
		end
	end

	// ----------------------------------------------------------------
	// Reply decision
	// ----------------------------------------------------------------
	always @* begin
		next_valid      = 1'b0;
		next_kind       = rsp_kind;
		next_slave      = rsp_slave;
		next_func       = rsp_func;
		next_exc_code   = rsp_exc_code;
		next_word       = rsp_word;
		next_word_valid = 1'b0;
		if (req_valid) begin
			next_slave    = req_addr;
			next_func     = req_func;
			next_exc_code = 8'h00;
			next_kind     = `MBD_REPLY_NONE;
			if (answer) begin
				next_valid = 1'b1;
				if (exc != 8'h00) begin
					next_kind     = `MBD_REPLY_EXC;
					next_func     = req_func | `MBD_EXC_FLAG;
					next_exc_code = exc;
				end else begin
					next_kind = `MBD_REPLY_NORMAL;
					if (is_ev) begin
						next_word       = cnt[C_EVENT];
						next_word_valid = 1'b1;
					end else if (is_diag && sub_ok) begin
						next_word       = cnt[bank_index(req_sub)];
						next_word_valid = 1'b1;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Reply strobes
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (!rstn) begin
			rsp_valid      <= 1'b0;
			rsp_word_valid <= 1'b0;
		end else begin
			rsp_valid      <= next_valid;
			rsp_word_valid <= next_word_valid;
		end
	end

	// ----------------------------------------------------------------
	// Reply fields
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (!rstn) begin
			rsp_kind     <= `MBD_REPLY_NONE;
			rsp_slave    <= 8'h00;
			rsp_func     <= 8'h00;
			rsp_exc_code <= 8'h00;
		end else begin
			rsp_kind     <= next_kind;
			rsp_slave    <= next_slave;
			rsp_func     <= next_func;
			rsp_exc_code <= next_exc_code;
		end
	end

	// ----------------------------------------------------------------
	// Reply counter word
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (!rstn)
			rsp_word <= {CW{1'b0}};
		else
			rsp_word <= next_word;
	end
endmodule
`default_nettype wire

// ===== verification/mbd_slave_checker.sv
// Reply-decision checker, bound to the slave diagnostic top.
// Assumes own_addr is static and one-cycle request pulses.
`timescale 1ns/100ps
`default_nettype none
module mbd_slave_checker (
	input wire logic       clk, rstn, req_valid, req_comm_err, req_overrun, req_lost, rsp_valid,
	input wire logic [7:0] req_addr, req_func, own_addr, rsp_func, rsp_exc_code,
	input wire logic [3:0] app_status,
	input wire logic [1:0] rsp_kind
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire e = req_comm_err | req_overrun | req_lost;
	wire ok = req_valid & !e & req_addr == own_addr & req_func == 8'h03;
	wire ex = ok & app_status != 4'h0;
	a_good_reply: assert property (ok && app_status == 0 |=> rsp_valid && rsp_kind == 2'h1)
		else $error("no normal reply");
	a_err_quiet: assert property (req_valid && e |=> !rsp_valid)
		else $error("reply after bad frame");
	a_exc_kind: assert property (ex |=> rsp_valid && rsp_kind == 2'h2)
		else $error("no exception reply");
	a_exc_func: assert property (ex |=> rsp_func == 8'h83)
		else $error("bad exception function");
	a_exc_code: assert property (ex && app_status < 12 |=> rsp_exc_code == $past(app_status))
		else $error("bad exception code");
	a_unimpl_addr: assert property (ok && app_status == 4'hc |=> rsp_exc_code == 8'h02)
		else $error("bad unimplemented code");
	a_addr_range: assert property (req_valid && (req_addr == 0 || req_addr > 8'hf7) |=> !rsp_valid)
		else $error("reply to bad address");
	a_reply_cause: assert property (rsp_valid |-> $past(req_valid))
		else $error("reply without request");
	c_normal: cover property (ok && app_status == 0);
	c_exc: cover property (ex);
	c_bcast: cover property (req_valid && req_addr == 0);
endmodule
`default_nettype wire

// ===== verification/mbd_master_model.sv
// Bus master model: one request per call, then the one-cycle answer window.
`timescale 1ns/100ps
`default_nettype none
module mbd_master_model (
	input  wire logic  clk, rsp_valid,
	output logic       req_valid,
	output logic [7:0] req_addr, req_func,
	output logic [15:0] req_sub,
	output logic [2:0] err
);
	initial {req_valid, req_addr, req_func, req_sub, err} = 0;
	task send(input [7:0] a, f, input [15:0] s, input [2:0] e, output logic got);
		@(posedge clk);
		#1 {req_valid, req_addr, req_func, req_sub, err} = {1'b1, a, f, s, e};
		@(posedge clk);
		#1 {req_valid, req_addr} = {1'b0, ~a};
		got = rsp_valid;
	endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Bench for the slave reply block; the master model drives requests.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk, rstn, got, req_valid, req_comm_err, req_overrun, req_lost, link_cfg_changed;
	logic rsp_valid, rsp_word_valid;
	logic [7:0] req_addr, req_func, own_addr, rsp_slave, rsp_func, rsp_exc_code;
	logic [15:0] req_sub, rsp_word;
	logic [3:0] app_status;
	logic [1:0] rsp_kind;
	int bad_count, checks_done, cyc;
	mbd_master_model u_mst (.*, .err({req_comm_err, req_overrun, req_lost}));
	mbd_slave_diag u_dut (.*);
	task chk(input [15:0] g, e);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task rd(input [15:0] s, e);
		u_mst.send(8'h2f, 8'h08, s, 0, got);
		chk(rsp_word, e);
	endtask
	task t_reply;
		for (int i = 0; i < 13; i++) begin
			app_status = i[3:0];
			u_mst.send(8'h2f, 8'h03, 0, 0, got);
			chk({got, rsp_kind, rsp_func}, i ? 11'h683 : 11'h503);
			if (i) chk(rsp_exc_code, 16'(i < 12 ? i : 2));
		end
		$display("reply test done");
	endtask
	task t_silent;
		app_status = 0;
		for (int i = 0; i < 5; i++) begin
			u_mst.send(i == 3 ? 8'h00 : i == 4 ? 8'hf8 : 8'h2f, 8'h03, 0, 3'b100 >> i, got);
			chk(got, 0);
		end
		$display("silent test done");
	endtask
	task t_count;
		u_mst.send(8'h2f, 8'h08, 16'h000a, 0, got);
		u_mst.send(8'h2f, 8'h03, 0, 3'b100, got);
		u_mst.send(8'h2f, 8'h03, 0, 3'b010, got);
		u_mst.send(8'h00, 8'h03, 0, 0, got);
		rd(16'h000c, 2);
		rd(16'h0012, 1);
		rd(16'h000f, 1);
		rd(16'h000b, 4);
		u_mst.send(8'h2f, 8'h0b, 0, 0, got);
		chk(rsp_word_valid, 1);
		chk(rsp_word, 5);
		link_cfg_changed = 1;
		repeat (4) @(posedge clk);
		rd(16'h000c, 0);
		$display("count test done");
	endtask
	task t_exc_count;
		app_status = 4'h7;
		u_mst.send(8'h2f, 8'h03, 0, 0, got);
		app_status = 4'h6;
		u_mst.send(8'h2f, 8'h03, 0, 0, got);
		app_status = 4'h0;
		u_mst.send(8'h00, 8'h03, 0, 3'b100, got);
		rd(16'h000d, 3);
		rd(16'h0010, 1);
		rd(16'h0011, 1);
		u_mst.send(8'h2f, 8'h08, 16'h0013, 0, got);
		chk({got, rsp_func}, 9'h188);
		chk(rsp_exc_code, 3);
		$display("exception count test done");
	endtask
	task results;
		$display("checks %0d bad %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 600) begin
			bad_count++;
			results;
		end
	end
	initial begin
		{rstn, link_cfg_changed, app_status, bad_count, checks_done, cyc} = 0;
		own_addr = 8'h2f;
		repeat (5) @(posedge clk);
		#1 rstn = 1;
		t_reply;
		t_silent;
		t_count;
		t_exc_count;
		results;
	end
endmodule
bind mbd_slave_diag mbd_slave_checker u_chk (.*);
`default_nettype wire
